// file: olm_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef OLM_MAP_SVH
`define OLM_MAP_SVH
`define REG_SPEED_CLK 8'h03
`define REG_PORT_FMT 8'h04
`define REG_MISC 8'h05
`define REG_STATUS 8'h06
`define SPEED_CLK_RST 8'h00
`define PORT_FMT_RST 8'h00
`define MISC_RST 8'h00
`define PB_SPEED_LSB 6
`define CP_SPEED_LSB 4
`define CP_OUT_CLK_SEL_BIT 0
`define IF_FMT_LSB 0
`define PB_OL_LSB 2
`define CP_OL_LSB 4
`define PB_MASTER_BIT 7
`define CP_MASTER_BIT 6
`define EXT_CLK_SRC_BIT 5
`define PORT_EN_BIT 0
`define ST_CFG_OK_BIT 0
`define ST_OVF_BIT 1
`define FMT_DELAYED 2'h1
`define EXT_BITS 24
`define CORE_CLK_NS 100
`define BCLK_PERIOD_NS 800
`define BCLK_HALF_CYC ((`BCLK_PERIOD_NS / `CORE_CLK_NS) / 2)
`define SAMPLE_DLY_CYC 2
`define FIFO_DEPTH 16
`endif

// file: olm_pkg.sv
// shared types and framing helpers for the one-line audio ports
package olm_pkg;
  typedef enum logic [1:0] {OL_NONE = 2'b00, OL_ONE = 2'b01, OL_TWO = 2'b10,
                            OL_RSVD = 2'b11} one_line_mode_t;
  typedef enum logic [1:0] {SPD_SINGLE = 2'b00, SPD_DOUBLE = 2'b01, SPD_QUAD = 2'b10,
                            SPD_RSVD = 2'b11} speed_t;
  typedef enum logic {PORT_IDLE = 1'b0, PORT_RUN = 1'b1} port_state_t;
  typedef logic [23:0] sample_t;

  function automatic logic [8:0] frame_bits(one_line_mode_t m);
    case (m)
      OL_ONE: return 9'h080;
      OL_TWO: return 9'h100;
      default: return 9'h040;
    endcase
  endfunction : frame_bits

  function automatic logic [5:0] slot_bits(one_line_mode_t m);
    case (m)
      OL_ONE: return 6'h14;
      OL_TWO: return 6'h18;
      default: return 6'h20;
    endcase
  endfunction : slot_bits

  function automatic logic [5:0] samp_bits(one_line_mode_t m);
    return (m == OL_ONE) ? 6'h14 : 6'h18;
  endfunction : samp_bits

  // true when slot position carries a sample bit
  function automatic logic bit_ok(one_line_mode_t m, logic dly, logic [2:0] ch,
                                  logic [5:0] pos);
    logic [2:0] nch;
    nch = (m == OL_NONE) ? 3'h2 : 3'h6;
    return (ch < nch) && (pos >= {5'h00, dly}) && (pos - {5'h00, dly} < samp_bits(m));
  endfunction : bit_ok

  // bit of a left-aligned 24-bit word, msb first
  function automatic logic [4:0] bit_idx(logic dly, logic [5:0] pos);
    return 5'h17 - 5'(pos - {5'h00, dly});
  endfunction : bit_idx
endpackage : olm_pkg

// file: olm_if.sv
// serial link between codec end and host/external-converter end
`timescale 1ns/1ps
interface olm_if;
  logic playback_bit_clock_o;
  logic playback_bit_clock_oe;
  logic playback_frame_clock_o;
  logic playback_frame_clock_oe;
  logic capture_bit_clock_o;
  logic capture_bit_clock_oe;
  logic capture_frame_clock_o;
  logic capture_frame_clock_oe;
  logic playback_bit_clock;
  logic playback_frame_clock;
  logic capture_bit_clock;
  logic capture_frame_clock;
  logic playback_serial_in_first;
  logic capture_serial_out;
  logic external_capture_in_a;
  logic external_capture_in_b;

  // undriven clock lines are pulled low
  assign playback_bit_clock = playback_bit_clock_oe & playback_bit_clock_o;
  assign playback_frame_clock = playback_frame_clock_oe & playback_frame_clock_o;
  assign capture_bit_clock = capture_bit_clock_oe & capture_bit_clock_o;
  assign capture_frame_clock = capture_frame_clock_oe & capture_frame_clock_o;

  modport device (
    output playback_bit_clock_o, playback_bit_clock_oe, playback_frame_clock_o,
    output playback_frame_clock_oe, capture_bit_clock_o, capture_bit_clock_oe,
    output capture_frame_clock_o, capture_frame_clock_oe, capture_serial_out,
    input playback_serial_in_first, external_capture_in_a, external_capture_in_b
  );
  modport host (
    input playback_bit_clock, playback_frame_clock, capture_bit_clock,
    input capture_frame_clock, capture_serial_out,
    output playback_serial_in_first, external_capture_in_a, external_capture_in_b
  );
endinterface : olm_if

// file: olm_device.sv
// codec end: mode registers, port clocks, one-line framing, playback fifo
`timescale 1ns/1ps
`include "olm_map.svh"

module olm_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  input wire logic core_clk_in, // core clock
  input wire logic srst_in, // sync reset
  input wire logic [WIDTH-1:0] in_data_in, // write word
  input wire logic in_valid_in, // write request
  output logic in_ready_out, // room left
  output logic [WIDTH-1:0] out_data_out, // head word
  output logic out_valid_out, // not empty
  input wire logic out_ready_in // head taken
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r, rd_r;

  assign in_ready_out = (wr_r - rd_r) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_r != rd_r;
  assign out_data_out = mem[rd_r[AW-1:0]];

  always_ff @(posedge core_clk_in) begin
    if (in_valid_in && in_ready_out) begin
      mem[wr_r[AW-1:0]] <= in_data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (in_valid_in && in_ready_out) wr_r <= wr_r + 1'b1;
      if (out_valid_out && out_ready_in) rd_r <= rd_r + 1'b1;
    end
  end
endmodule : olm_fifo

module olm_device
  import olm_pkg::*;
(
  input wire logic core_clk_in, // 10 MHz core clock
  input wire logic srst_in, // sync reset, high
  input wire logic [7:0] reg_addr_in, // register index
  input wire logic reg_wr_in, // write strobe
  input wire logic [7:0] reg_wdata_in, // write data
  output logic [7:0] reg_rdata_out, // read data, one cycle late
  input wire sample_t int_left_in, // internal converter left
  input wire sample_t int_right_in, // internal converter right
  output logic pb_valid_out, // playback word ready
  input wire logic pb_ready_in, // playback word taken
  output logic [2:0] pb_chan_out, // playback channel, 0 based
  output sample_t pb_data_out, // playback sample, left aligned
  olm_if.device link // serial pins
);
  logic [7:0] spd_r, fmt_r, misc_r;
  logic ovf_r;
  one_line_mode_t ol [2];
  speed_t spd [2];
  logic [8:0] fb [2];
  logic dly [2];
  logic pb_ok, cp_ok, ext_ok, run_ok, clk_sel, src;
  port_state_t state_r;
  logic [2:0] div_r;
  logic tick, fall, bclk_r;
  logic [1:0] rise_d_r;
  logic [7:0] cnt_r [2];
  logic [7:0] cnt_nxt [2];
  logic [2:0] ch_r [2];
  logic [2:0] ch_nxt [2];
  logic [5:0] pos_r [2];
  logic [5:0] pos_nxt [2];
  logic last [2];
  logic fclk_r [2];
  logic [2:0] s1_r, s2_r;
  sample_t cap_src [8];
  sample_t cap_r [8];
  sample_t ext_r [4];
  sample_t ext_sh_r [2];
  logic [8:0] half, ec, hp;
  logic eh;
  sample_t pb_sh_r;
  logic push_r, fifo_rdy, fifo_vld;
  logic [26:0] push_w, fifo_w;
  logic sdout_r, pbm_r, cpm_r;

  // register writes; reads have no side effects, the status overflow flag clears on a write of 1
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      spd_r <= `SPEED_CLK_RST;
      fmt_r <= `PORT_FMT_RST;
      misc_r <= `MISC_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `REG_SPEED_CLK: spd_r <= reg_wdata_in;
        `REG_PORT_FMT: fmt_r <= reg_wdata_in;
        `REG_MISC: misc_r <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      case (reg_addr_in)
        `REG_SPEED_CLK: reg_rdata_out <= spd_r;
        `REG_PORT_FMT: reg_rdata_out <= fmt_r;
        `REG_MISC: reg_rdata_out <= misc_r;
        `REG_STATUS: reg_rdata_out <= {6'h00, ovf_r, run_ok};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  always_comb begin
    ol[0] = one_line_mode_t'(fmt_r[`PB_OL_LSB +: 2]);
    ol[1] = one_line_mode_t'(fmt_r[`CP_OL_LSB +: 2]);
    spd[0] = speed_t'(spd_r[`PB_SPEED_LSB +: 2]);
    spd[1] = speed_t'(spd_r[`CP_SPEED_LSB +: 2]);
    clk_sel = spd_r[`CP_OUT_CLK_SEL_BIT];
    src = ~misc_r[`EXT_CLK_SRC_BIT] ;
    fb[0] = frame_bits(ol[0]);
    fb[1] = clk_sel ? frame_bits(ol[1]) : fb[0];
    for (int p = 0; p < 2; p++) begin
      dly[p] = (ol[p] == OL_NONE) && (fmt_r[`IF_FMT_LSB +: 2] == `FMT_DELAYED);
    end
  end

  // illegal mode/speed/role combinations keep the ports idle
  function automatic logic port_ok(one_line_mode_t m, speed_t s, logic master);
    case (m)
      OL_NONE: return s != SPD_RSVD;
      OL_ONE: return (s == SPD_SINGLE) || (s == SPD_DOUBLE);
      OL_TWO: return (s == SPD_SINGLE) && master;
      default: return 1'b0;
    endcase
  endfunction : port_ok

  always_comb begin
    pb_ok = port_ok(ol[0], spd[0], misc_r[`PB_MASTER_BIT]);
    cp_ok = port_ok(ol[1], spd[1], misc_r[`CP_MASTER_BIT]) &&
            (clk_sel || ((spd[1] == spd[0]) && (fb[0] >= frame_bits(ol[1]))));
    run_ok = pb_ok && cp_ok;
    ext_ok = (ol[1] != OL_NONE) &&
             (((fb[src] == 9'h040) && ((spd[src] == SPD_SINGLE) || (spd[src] == SPD_DOUBLE))) ||
              ((fb[src] == 9'h080) && (spd[src] == SPD_SINGLE)));
  end

  // ports leave idle only once the enable bit is set on a legal setup
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_r <= PORT_IDLE;
    end else begin
      case (state_r)
        PORT_IDLE: if (misc_r[`PORT_EN_BIT] && run_ok) state_r <= PORT_RUN;
        PORT_RUN: if (!misc_r[`PORT_EN_BIT] || !run_ok) state_r <= PORT_IDLE;
        default: state_r <= PORT_IDLE;
      endcase
    end
  end

  assign tick = (state_r == PORT_RUN) && (div_r == 3'(`BCLK_HALF_CYC - 1));
  assign fall = tick && bclk_r;

  always_ff @(posedge core_clk_in) begin
    if (srst_in || state_r == PORT_IDLE) begin
      div_r <= 3'h0;
      bclk_r <= 1'b1;
      rise_d_r <= 2'h0;
    end else begin
      div_r <= tick ? 3'h0 : div_r + 3'h1;
      if (tick) bclk_r <= ~bclk_r;
      // inputs reach us through two flops, so sample two cycles after the rise, mid high phase
      rise_d_r <= {rise_d_r[0], tick && !bclk_r};
    end
  end

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      last[p] = ({1'b0, cnt_r[p]} == fb[p] - 9'h001);
      cnt_nxt[p] = last[p] ? 8'h00 : cnt_r[p] + 8'h01;
      if (last[p] || pos_r[p] == slot_bits(ol[p]) - 6'h01) begin
        pos_nxt[p] = 6'h00;
        ch_nxt[p] = last[p] ? 3'h0 : ((ch_r[p] == 3'h7) ? ch_r[p] : ch_r[p] + 3'h1);
      end else begin
        pos_nxt[p] = pos_r[p] + 6'h01;
        ch_nxt[p] = ch_r[p];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    for (int p = 0; p < 2; p++) begin
      if (srst_in || state_r == PORT_IDLE) begin
        cnt_r[p] <= 8'(fb[p] - 9'h001);
        ch_r[p] <= 3'h7;
        pos_r[p] <= 6'h00;
        fclk_r[p] <= 1'b0;
      end else if (fall) begin
        cnt_r[p] <= cnt_nxt[p];
        ch_r[p] <= ch_nxt[p];
        pos_r[p] <= pos_nxt[p];
        fclk_r[p] <= ({1'b0, cnt_nxt[p]} < (fb[p] >> 1));
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
    end else begin
      s1_r <= {link.external_capture_in_b, link.external_capture_in_a,
               link.playback_serial_in_first};
      s2_r <= s1_r;
    end
  end

  // capture channels: internal pair first, then the four external ones
  always_comb begin
    cap_src[0] = int_left_in;
    cap_src[1] = int_right_in;
    for (int i = 0; i < 4; i++) cap_src[i+2] = ext_ok ? ext_r[i] : '0;
    cap_src[6] = '0;
    cap_src[7] = '0;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sdout_r <= 1'b0;
      for (int i = 0; i < 8; i++) cap_r[i] <= '0;
    end else if (state_r == PORT_IDLE) begin
      sdout_r <= 1'b0;
    end else if (fall) begin
      if (last[1]) cap_r <= cap_src;
      if (bit_ok(ol[1], dly[1], ch_nxt[1], pos_nxt[1])) begin
        sdout_r <= last[1] ? cap_src[ch_nxt[1]][bit_idx(dly[1], pos_nxt[1])]
                           : cap_r[ch_nxt[1]][bit_idx(dly[1], pos_nxt[1])];
      end else begin
        sdout_r <= 1'b0;
      end
    end
  end

  // external lines: fixed 24-bit left-justified halves, port format ignored
  always_comb begin
    half = fb[src] >> 1;
    ec = {1'b0, cnt_r[src]};
    eh = ec >= half;
    hp = eh ? ec - half : ec;
  end

  always_ff @(posedge core_clk_in) begin
    for (int l = 0; l < 2; l++) begin
      if (srst_in) begin
        ext_sh_r[l] <= '0;
        ext_r[2*l] <= '0;
        ext_r[2*l+1] <= '0;
      end else if (rise_d_r[1] && hp < 9'(`EXT_BITS)) begin
        ext_sh_r[l] <= {ext_sh_r[l][22:0], s2_r[l+1]};
        if (hp == 9'(`EXT_BITS - 1)) ext_r[2*l + int'(eh)] <= {ext_sh_r[l][22:0], s2_r[l+1]};
      end
    end
  end

  // playback: every channel arrives on the first data line
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pb_sh_r <= '0;
      push_r <= 1'b0;
      push_w <= '0;
      ovf_r <= 1'b0;
    end else begin
      push_r <= 1'b0;
      if (rise_d_r[1] && bit_ok(ol[0], dly[0], ch_r[0], pos_r[0])) begin
        pb_sh_r <= {pb_sh_r[22:0], s2_r[0]};
        if (pos_r[0] - {5'h00, dly[0]} == samp_bits(ol[0]) - 6'h01) begin
          push_r <= 1'b1;
          push_w <= {ch_r[0], sample_t'({pb_sh_r[22:0], s2_r[0]} << (6'h18 - samp_bits(ol[0])))};
        end
      end
      // a stream cannot stall: a word that finds the fifo full is lost and flagged
      if (push_r && !fifo_rdy) begin
        ovf_r <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == `REG_STATUS && reg_wdata_in[`ST_OVF_BIT]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  olm_fifo #(.WIDTH(27), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .in_data_in(push_w),
    .in_valid_in(push_r),
    .in_ready_out(fifo_rdy),
    .out_data_out(fifo_w),
    .out_valid_out(fifo_vld),
    .out_ready_in(!pb_valid_out || pb_ready_in)
  );

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pb_valid_out <= 1'b0;
      pb_chan_out <= 3'h0;
      pb_data_out <= '0;
    end else if (!pb_valid_out || pb_ready_in) begin
      pb_valid_out <= fifo_vld;
      pb_chan_out <= fifo_w[26:24];
      pb_data_out <= fifo_w[23:0];
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pbm_r <= 1'b0;
      cpm_r <= 1'b0;
    end else begin
      pbm_r <= misc_r[`PB_MASTER_BIT];
      cpm_r <= misc_r[`CP_MASTER_BIT];
    end
  end

  assign link.playback_bit_clock_o = bclk_r;
  assign link.capture_bit_clock_o = bclk_r;
  assign link.playback_frame_clock_o = fclk_r[0];
  assign link.capture_frame_clock_o = fclk_r[1];
  assign link.playback_bit_clock_oe = pbm_r;
  assign link.playback_frame_clock_oe = pbm_r;
  assign link.capture_bit_clock_oe = cpm_r;
  assign link.capture_frame_clock_oe = cpm_r;
  assign link.capture_serial_out = sdout_r;
endmodule : olm_device

// file: olm_host.sv
// host end: playback source, capture sink and two external stereo converters
`timescale 1ns/1ps
`include "olm_map.svh"

module olm_host
  import olm_pkg::*;
(
  input wire logic core_clk_in, // 10 MHz core clock
  input wire logic srst_in, // sync reset, high
  input wire one_line_mode_t pb_mode_in, // playback framing in use
  input wire one_line_mode_t cp_mode_in, // capture framing in use
  input wire logic [5:0][23:0] pb_samples_in, // six playback samples, ch1 at [0]
  input wire logic [3:0][23:0] ext_samples_in, // converter samples a-l, a-r, b-l, b-r
  output logic cap_valid_out, // one-cycle pulse per capture word
  output logic [2:0] cap_chan_out, // capture channel, 0 based
  output sample_t cap_data_out, // capture sample, left aligned
  olm_if.host link // serial pins
);
  logic [3:0] s1_r, s2_r, prev_r;
  logic [4:0] d1_r, d2_r;
  logic fl_r [2];
  logic start [2];
  logic fall [2];
  logic rise [2];
  logic [2:0] ch_r [2];
  logic [2:0] ch_nxt [2];
  logic [5:0] pos_r [2];
  logic [5:0] pos_nxt [2];
  logic [7:0] hc_r, hc_nxt;
  one_line_mode_t md [2];
  logic [5:0][23:0] tx_r;
  logic [3:0][23:0] ex_r;
  sample_t rx_r;
  logic sdin_r, ea_r, eb_r;

  // clocks and frames: bits 0/1 playback, 2/3 capture
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      s1_r <= 4'h0;
      s2_r <= 4'h0;
      prev_r <= 4'h0;
      d1_r <= 5'h00;
      d2_r <= 5'h00;
    end else begin
      s1_r <= {link.capture_frame_clock, link.capture_bit_clock,
               link.playback_frame_clock, link.playback_bit_clock};
      s2_r <= s1_r;
      prev_r <= s2_r;
      d1_r <= {4'h0, link.capture_serial_out};
      d2_r <= d1_r;
    end
  end

  always_comb begin
    md[0] = pb_mode_in;
    md[1] = cp_mode_in;
    for (int p = 0; p < 2; p++) begin
      fall[p] = prev_r[2*p] && !s2_r[2*p];
      rise[p] = !prev_r[2*p] && s2_r[2*p];
      start[p] = s2_r[2*p+1] && !fl_r[p];
      if (start[p] || pos_r[p] == slot_bits(md[p]) - 6'h01) begin
        pos_nxt[p] = 6'h00;
        ch_nxt[p] = start[p] ? 3'h0 : ((ch_r[p] == 3'h7) ? ch_r[p] : ch_r[p] + 3'h1);
      end else begin
        pos_nxt[p] = pos_r[p] + 6'h01;
        ch_nxt[p] = ch_r[p];
      end
    end
    hc_nxt = (s2_r[3] != fl_r[1]) ? 8'h00 : hc_r + 8'h01;
  end

  always_ff @(posedge core_clk_in) begin
    for (int p = 0; p < 2; p++) begin
      if (srst_in) begin
        fl_r[p] <= 1'b0;
        ch_r[p] <= 3'h7;
        pos_r[p] <= 6'h00;
      end else if (fall[p]) begin
        fl_r[p] <= s2_r[2*p+1];
        ch_r[p] <= ch_nxt[p];
        pos_r[p] <= pos_nxt[p];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      tx_r <= '0;
      sdin_r <= 1'b0;
    end else if (fall[0]) begin
      if (start[0]) tx_r <= pb_samples_in;
      if (bit_ok(md[0], 1'b0, ch_nxt[0], pos_nxt[0])) begin
        sdin_r <= start[0] ? pb_samples_in[ch_nxt[0]][bit_idx(1'b0, pos_nxt[0])]
                           : tx_r[ch_nxt[0]][bit_idx(1'b0, pos_nxt[0])];
      end else begin
        sdin_r <= 1'b0;
      end
    end
  end

  // converters follow the capture clocks: high frame clock is the left half
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      hc_r <= 8'h00;
      ex_r <= '0;
      ea_r <= 1'b0;
      eb_r <= 1'b0;
    end else if (fall[1]) begin
      hc_r <= hc_nxt;
      if (start[1]) ex_r <= ext_samples_in;
      if (hc_nxt < 8'(`EXT_BITS)) begin
        ea_r <= ext_samples_in[{1'b0, !s2_r[3]}][5'h17 - 5'(hc_nxt)];
        eb_r <= ext_samples_in[{1'b1, !s2_r[3]}][5'h17 - 5'(hc_nxt)];
        if (!start[1]) begin
          ea_r <= ex_r[{1'b0, !s2_r[3]}][5'h17 - 5'(hc_nxt)];
          eb_r <= ex_r[{1'b1, !s2_r[3]}][5'h17 - 5'(hc_nxt)];
        end
      end else begin
        ea_r <= 1'b0;
        eb_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rx_r <= '0;
      cap_valid_out <= 1'b0;
      cap_chan_out <= 3'h0;
      cap_data_out <= '0;
    end else begin
      cap_valid_out <= 1'b0;
      if (rise[1] && bit_ok(md[1], 1'b0, ch_r[1], pos_r[1])) begin
        rx_r <= {rx_r[22:0], d2_r[0]};
        if (pos_r[1] == samp_bits(md[1]) - 6'h01) begin
          cap_valid_out <= 1'b1;
          cap_chan_out <= ch_r[1];
          cap_data_out <= sample_t'({rx_r[22:0], d2_r[0]} << (6'h18 - samp_bits(md[1])));
        end
      end
    end
  end

  assign link.playback_serial_in_first = sdin_r;
  assign link.external_capture_in_a = ea_r;
  assign link.external_capture_in_b = eb_r;
endmodule : olm_host

// file: olm_link_asserts.sv
// concurrent checks on the one-line serial link
`timescale 1ns/1ps
module olm_link_asserts (
  input wire logic core_clk_in, // core clock
  input wire logic srst_in, // sync reset
  input wire logic playback_bit_clock, // bit clock
  input wire logic playback_frame_clock, // frame clock
  input wire logic capture_bit_clock, // capture bit clock
  input wire logic playback_bit_clock_oe, // bit clock drive
  input wire logic playback_frame_clock_oe, // frame clock drive
  input wire logic capture_bit_clock_oe, // capture clock drive
  input wire logic capture_serial_out // capture data
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  wire bc = playback_bit_clock;
  wire fc = playback_frame_clock;
  wire cbc = capture_bit_clock;
  wire sd = capture_serial_out;
  // cycles held at the current frame level, saturating
  logic [10:0] run_r;
  logic [10:0] hi_r;
  always_ff @(posedge core_clk_in) begin
    if (srst_in) run_r <= 11'h000;
    else if ($changed(fc)) run_r <= 11'h001;
    else if (run_r != 11'h7FF) run_r <= run_r + 11'h001;
  end
  always_ff @(posedge core_clk_in) begin
    if (srst_in) hi_r <= 11'h000;
    else if ($fell(fc)) hi_r <= run_r;
  end
  a_bclk_low_half:
  assert property ($fell(bc) |-> !bc[*4] ##1 bc) else $error("bit clock low phase wrong");
  a_bclk_high_half:
  assert property ($rose(bc) |-> bc[*4]) else $error("bit clock high phase short");
  a_frame_half_len:
  assert property ($fell(fc) |-> run_r inside {11'h100, 11'h200, 11'h400})
    else $error("frame half length wrong");
  a_frame_duty_even:
  assert property ($rose(fc) && hi_r != 11'h000 |-> run_r == hi_r)
    else $error("frame low half differs from high half");
  a_frame_at_fall:
  assert property ($rose(fc) |-> !bc) else $error("frame start off bit clock fall");
  a_data_on_low:
  assert property ($changed(sd) |-> !cbc) else $error("capture data moved while clock high");
  a_cap_clk_shared:
  assert property (capture_bit_clock_oe && playback_bit_clock_oe |-> cbc == bc)
    else $error("capture bit clock not playback bit clock");
  a_pb_drive_pair:
  assert property (playback_bit_clock_oe == playback_frame_clock_oe)
    else $error("playback clocks driven apart");
  c_frame: cover property ($fell(fc));
  c_data: cover property ($rose(sd));
  c_cap_clk: cover property ($rose(cbc));
endmodule : olm_link_asserts

// file: tb_top.sv
// self-checking bench for both ends of the one-line link
`timescale 1ns/1ps
module tb_top import olm_pkg::*; ;
  `define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic pb_rdy = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] rdat;
  sample_t il = 24'hA5C3E1;
  sample_t ir = 24'h5A3C1E;
  sample_t pbd, cpd;
  logic [5:0][23:0] pbs;
  logic [3:0][23:0] exs;
  one_line_mode_t pbm = OL_NONE;
  one_line_mode_t cpm = OL_NONE;
  logic pbv, cv;
  logic [2:0] pbc, cc;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  olm_if lk ();
  olm_device olm_device_i (.core_clk_in(clk), .srst_in(srst), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdat), .reg_rdata_out(rdat), .int_left_in(il),
    .int_right_in(ir), .pb_valid_out(pbv), .pb_ready_in(pb_rdy), .pb_chan_out(pbc),
    .pb_data_out(pbd), .link(lk));
  olm_host olm_host_i (.core_clk_in(clk), .srst_in(srst), .pb_mode_in(pbm), .cp_mode_in(cpm),
    .pb_samples_in(pbs), .ext_samples_in(exs), .cap_valid_out(cv), .cap_chan_out(cc),
    .cap_data_out(cpd), .link(lk));
  olm_link_asserts olm_link_asserts_i (.core_clk_in(clk), .srst_in(srst),
    .playback_bit_clock(lk.playback_bit_clock), .playback_frame_clock(lk.playback_frame_clock),
    .capture_bit_clock(lk.capture_bit_clock), .playback_bit_clock_oe(lk.playback_bit_clock_oe),
    .playback_frame_clock_oe(lk.playback_frame_clock_oe),
    .capture_bit_clock_oe(lk.capture_bit_clock_oe), .capture_serial_out(lk.capture_serial_out));
  initial forever #50 clk = ~clk;
  task automatic wrap_up();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic rst();
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask : rst
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    addr <= a;
    repeat (2) @(posedge clk);
    v = rdat;
  endtask : rd
  // skips 3200 cycles (three one-line frames, six stereo ones) so external samples have crossed, then watches 1100 cycles
  task automatic collect(input int nch, input sample_t m);
    int np = 0;
    int nc = 0;
    sample_t ec;
    repeat (3200) @(posedge clk);
    repeat (1100) begin
      @(posedge clk);
      if (pbv === 1'b1) begin
        `CHK(pbd, pbs[pbc] & m)
        np++;
      end
      if (cv === 1'b1) begin
        ec = (cc == 3'h0) ? il : (cc == 3'h1) ? ir : exs[cc - 3'h2];
        `CHK(cc < 3'(nch), 1'b1)
        `CHK(cpd, ec & m)
        nc++;
      end
    end
    `CHK(np >= nch && nc >= nch, 1'b1)
  endtask : collect
  task automatic t_regs();
    logic [7:0] v;
    rst();
    for (int i = 3; i < 6; i++) begin
      rd(8'(i), v);
      `CHK(v, 8'h00)
    end
    wreg(8'h05, 8'h20);
    rd(8'h05, v);
    `CHK(v, 8'h20)
    rd(8'h07, v);
    `CHK(v, 8'h00)
    $display("register test done");
  endtask : t_regs
  task automatic t_legal();
    logic [7:0] v;
    logic [23:0] tb [6] = '{24'h001401, 24'h501401, 24'hA01400, 24'h401400, 24'h500800,
      24'h000801};
    rst();
    wreg(8'h05, 8'hC0);
    foreach (tb[i]) begin
      wreg(8'h03, tb[i][23:16]);
      wreg(8'h04, tb[i][15:8]);
      rd(8'h06, v);
      `CHK(v[0], tb[i][0])
    end
    $display("legality test done");
  endtask : t_legal
  task automatic t_one_line();
    pbm <= OL_ONE;
    cpm <= OL_ONE;
    rst();
    wreg(8'h03, 8'h00);
    wreg(8'h04, 8'h15);
    wreg(8'h05, 8'hC1);
    collect(6, 24'hFFFFF0);
    $display("one-line test done");
  endtask : t_one_line
  // runs on from the one-line setup so words outpace the stalled reader
  task automatic t_fifo();
    logic [7:0] v;
    int n = 0;
    pb_rdy <= 1'b0;
    repeat (3300) @(posedge clk);
    rd(8'h06, v);
    `CHK(v[1], 1'b1)
    pb_rdy <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (pbv === 1'b1) n++;
    end
    `CHK(n inside {16, 17}, 1'b1)
    wreg(8'h06, 8'h02);
    rd(8'h06, v);
    `CHK(v[1], 1'b0)
    $display("fifo test done");
  endtask : t_fifo
  task automatic t_stereo();
    pbm <= OL_NONE;
    cpm <= OL_NONE;
    rst();
    wreg(8'h04, 8'h00);
    wreg(8'h05, 8'hC1);
    collect(2, 24'hFFFFFF);
    $display("stereo test done");
  endtask : t_stereo
  initial begin
    for (int i = 0; i < 6; i++) pbs[i] = 24'h2468AC + 24'(i) * 24'h111111;
    for (int i = 0; i < 4; i++) exs[i] = 24'h13579B + 24'(i) * 24'h0F0F0F;
    t_regs();
    t_legal();
    t_one_line();
    t_fifo();
    t_stereo();
    wrap_up();
  end
endmodule : tb_top
